//--- rtl/alert_pulser.sv
// Alert pulse generator: each source with a pending request gets one fixed-width pulse.
// Assumes requests are single-cycle strobes on the core clock.
`timescale 1ns/1ps
`default_nettype none
module alert_pulser #(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] req,
   output logic pulse
);
   logic [1:0] pend;
   logic [3:0] cnt;
   logic gap;
   wire [1:0] next_pend = pend | req;
   // Queued events keep a low gap between pulses so each is seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend <= 2'h0;
         cnt <= 4'h0;
         pulse <= 1'b0;
         gap <= 1'b0;
      end else if (ce) begin
         if (pulse) begin
            pend <= next_pend;
            if (cnt == 4'(WIDTH - 1)) begin
               pulse <= 1'b0;
               gap <= 1'b1;
            end
            cnt <= cnt + 4'h1;
         end else if (gap) begin
            pend <= next_pend;
            gap <= 1'b0;
         end else if (next_pend != 2'h0) begin
            pulse <= 1'b1;
            cnt <= 4'h0;
            pend <= next_pend[0] ? {next_pend[1], 1'b0} : 2'h0;
         end
      end
   end
   property p_width;
      @(posedge clk) disable iff (rst)
      ($rose(pulse) && ce) |-> pulse [*4];
   endproperty
   a_width: assert property (p_width) else $error("Alert pulse too short");
endmodule
`default_nettype wire

//--- rtl/charger_control_sequencer.sv
// Control and status sequencing of a single-cell charger: floor mode, input cap,
// current search, boost entry, power sharing flags, charge cycle and indicator.
// Assumes analog comparators arrive as synchronous levels; host bits are plain ports.
// Notes on behaviour
// - Absolute floor select lets host write floor
// - Otherwise floor is read-only, set by algorithm
// - Alert pulse once floor threshold established
// - Below 2.2 V cap is min(200 mA, setting)
// - Above 2.2 V use pin with setting/active cap
// - Search enabled at reset; runs after DCP/HV adapter
// - Host run-now bit forces search any source
// - Active cap reported, clamped by pin if enabled
// - Boost needs all conditions, starts after 30 ms
// - Boost rate writes ignored while boost enabled
// - Boost sets source kind 111, voltage selectable
// - Min system flag high while regulating minimum
// - Floor/cap active flags show enforced limit
// - Over-limit lowers charge current until satisfied
// - New cycle only when all start conditions hold
// - Terminate on low current, high voltage, no regulation
// - Recharge below threshold or host toggles restart
// - Indicator low charging, high done, blink fault
// - Phase code per state; alert at completion
// - Charge current chosen by battery voltage band
// - Regulation suspends termination, halves timer rate
// - Defaults for voltage, currents, timer at reset
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"
module charger_control_sequencer #(
   parameter int BOOST_DELAY = `BOOST_DELAY_CYCLES,
   parameter int TIMER_WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Host-written control bits, algorithm results and comparator levels
   input wire logic absoluteFloorSelect,
   input wire logic floorWrite,
   input wire logic [7:0] floorWriteData,
   input wire logic [7:0] floorAlgoValue,
   input wire logic floorAlgoDone,
   input wire logic [5:0] inputCurrentCapSetting,
   input wire logic [5:0] currentCapPin,
   input wire logic currentCapPinEnable,
   input wire logic inputCurrentSearchEnable,
   input wire logic runCurrentSearchNow,
   input wire logic searchDone,
   input wire logic [5:0] searchResult,
   input wire logic chargingPortDetected,
   input wire logic sysAbove2v2,
   input wire logic batAboveLow,
   input wire logic inputBelowSleep,
   input wire logic hostSupplyPin,
   input wire logic boostEnableBit,
   input wire logic thermBoostOk,
   input wire logic rateWrite,
   input wire logic rateWriteData,
   input wire logic [3:0] boostOutputVoltageSelect,
   input wire logic [2:0] sourceKindDetected,
   input wire logic sysAtMinimum,
   input wire logic inputOverCurrent,
   input wire logic inputUnderFloor,
   input wire logic thermalRegulating,
   input wire logic converterRunning,
   input wire logic chargeEnableBit,
   input wire logic chargeAllowPin_n,
   input wire logic [6:0] fastChargeCurrentSetting,
   input wire logic thermFault,
   input wire logic batterySwitchOffBit,
   input wire logic currentBelowTerm,
   input wire logic batAboveRecharge,
   input wire logic batAbove2v,
   input wire logic batAbove3v,
   input wire logic indicatorDisableBit,
   input wire logic timerTick,
   input wire logic [TIMER_WIDTH-1:0] timerLimit,
   // Status outputs
   output logic [7:0] inputVoltageFloor,
   output logic [5:0] activeInputCurrentCap,
   output logic [5:0] appliedInputCap,
   output logic searchRunning,
   output logic boostActive,
   output logic boostRateSelect,
   output logic [3:0] boostVoltage,
   output logic [2:0] inputSourceKind,
   output logic minSystemRegulatingFlag,
   output logic voltageFloorActiveFlag,
   output logic currentCapActiveFlag,
   output logic chargeReduce,
   output logic [1:0] chargePhaseCode,
   output logic [1:0] currentSelect,
   output logic indicatorOut,
   output logic indicatorOe_n,
   output logic hostAlert,
   output logic safetyFault,
   output logic [5:0] chargeVoltageCode,
   output logic [3:0] precharge,
   output logic [3:0] termination,
   output logic [1:0] safetyHours
);
   charger_pkg::chg_state_t state;
   charger_pkg::chg_state_t next_state;
   logic [24:0] boostCnt;
   logic [22:0] blinkCnt;
   logic prevEnable;
   logic prevAllow;
   logic timerExpired;
   logic [1:0] alertReq;

   wire regulating = inputOverCurrent || inputUnderFloor;
   wire regAny = regulating || thermalRegulating;
   wire canStart = converterRunning && chargeEnableBit && !chargeAllowPin_n
      && (fastChargeCurrentSetting != 7'h0) && !thermFault && !timerExpired
      && !batterySwitchOffBit && !safetyFault;
   wire toggled = (prevEnable && !chargeEnableBit) || (!prevAllow && chargeAllowPin_n);
   wire terminate = currentBelowTerm && batAboveRecharge && !regAny;
   wire boostOk = batAboveLow && inputBelowSleep && hostSupplyPin && boostEnableBit
      && thermBoostOk;
   wire [5:0] pinClamp = currentCapPinEnable ? currentCapPin : 6'h3f;
   wire [5:0] baseCap = inputCurrentSearchEnable ? activeInputCurrentCap
      : inputCurrentCapSetting;
   wire [5:0] runCap = (baseCap < pinClamp) ? baseCap : pinClamp;
   wire [5:0] softCap = (inputCurrentCapSetting < `SOFTSTART_CAP) ? inputCurrentCapSetting
      : `SOFTSTART_CAP;
   wire [5:0] next_applied = sysAbove2v2 ? runCap : softCap;
   wire [5:0] next_active = (searchDone && searchRunning) ? searchResult
      : inputCurrentCapSetting;
   wire [5:0] next_activeClamped = (next_active < pinClamp) ? next_active : pinClamp;
   wire startSearch = (inputCurrentSearchEnable && chargingPortDetected)
      || runCurrentSearchNow;
   wire charging = (state == charger_pkg::CHG_PRE) || (state == charger_pkg::CHG_FAST);
   wire fault = (charging && thermFault) || safetyFault;
   wire [1:0] next_phase = (state == charger_pkg::CHG_PRE) ? `PHASE_PRE
      : (state == charger_pkg::CHG_FAST) ? `PHASE_FAST
      : (state == charger_pkg::CHG_DONE) ? `PHASE_DONE : `PHASE_OFF;
   wire next_indicator = !(charging && !fault) && !(fault && !blinkCnt[`BLINK_BIT]);
   wire boostReady = boostOk && (boostCnt >= 25'(BOOST_DELAY));

   always_comb begin
      next_state = state;
      case (state)
         charger_pkg::CHG_IDLE: begin
            if (canStart) begin
               next_state = batAbove3v ? charger_pkg::CHG_FAST : charger_pkg::CHG_PRE;
            end
         end
         charger_pkg::CHG_PRE: begin
            if (!canStart) begin
               next_state = charger_pkg::CHG_IDLE;
            end else if (batAbove3v) begin
               next_state = charger_pkg::CHG_FAST;
            end
         end
         charger_pkg::CHG_FAST: begin
            if (!canStart) begin
               next_state = charger_pkg::CHG_IDLE;
            end else if (terminate) begin
               next_state = charger_pkg::CHG_DONE;
            end
         end
         charger_pkg::CHG_DONE: begin
            // Host toggle returns to idle so the next pass rechecks all start terms
            if (toggled) begin
               next_state = charger_pkg::CHG_IDLE;
            end else if (!batAboveRecharge && canStart) begin
               next_state = charger_pkg::CHG_IDLE;
            end
         end
         default: next_state = charger_pkg::CHG_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= charger_pkg::CHG_IDLE;
         prevEnable <= 1'b0;
         prevAllow <= 1'b1;
         blinkCnt <= 23'h0;
      end else if (ce) begin
         state <= next_state;
         prevEnable <= chargeEnableBit;
         prevAllow <= chargeAllowPin_n;
         blinkCnt <= blinkCnt + 23'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         inputVoltageFloor <= 8'h0;
         activeInputCurrentCap <= 6'h0;
         appliedInputCap <= 6'h0;
         searchRunning <= 1'b0;
         alertReq <= 2'h0;
      end else if (ce) begin
         if (absoluteFloorSelect) begin
            if (floorWrite) begin
               inputVoltageFloor <= floorWriteData;
            end
         end else if (floorAlgoDone) begin
            inputVoltageFloor <= floorAlgoValue;
         end
         alertReq <= {state == charger_pkg::CHG_FAST && next_state == charger_pkg::CHG_DONE,
            floorAlgoDone};
         if (startSearch) begin
            searchRunning <= 1'b1;
         end else if (searchDone) begin
            searchRunning <= 1'b0;
         end
         if (!inputCurrentSearchEnable || (searchRunning && searchDone)) begin
            activeInputCurrentCap <= next_activeClamped;
         end
         appliedInputCap <= next_applied;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boostCnt <= 25'h0;
         boostActive <= 1'b0;
         boostRateSelect <= 1'b0;
         boostVoltage <= `BOOST_VOLT_RST;
         inputSourceKind <= 3'h0;
      end else if (ce) begin
         boostCnt <= boostOk ? (boostReady ? boostCnt : boostCnt + 25'h1) : 25'h0;
         boostActive <= boostReady;
         if (rateWrite && !boostEnableBit) begin
            boostRateSelect <= rateWriteData;
         end
         boostVoltage <= boostOutputVoltageSelect;
         inputSourceKind <= boostReady ? `SRC_KIND_BOOST : sourceKindDetected;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         minSystemRegulatingFlag <= 1'b0;
         voltageFloorActiveFlag <= 1'b0;
         currentCapActiveFlag <= 1'b0;
         chargeReduce <= 1'b0;
         chargePhaseCode <= `PHASE_OFF;
         currentSelect <= 2'h0;
         indicatorOut <= 1'b1;
         indicatorOe_n <= 1'b1;
         safetyFault <= 1'b0;
         chargeVoltageCode <= `CHG_VOLT_RST;
         precharge <= `PRE_CUR_RST;
         termination <= `TERM_CUR_RST;
         safetyHours <= `SAFETY_HOURS_RST;
      end else if (ce) begin
         minSystemRegulatingFlag <= sysAtMinimum;
         voltageFloorActiveFlag <= inputUnderFloor;
         currentCapActiveFlag <= inputOverCurrent;
         chargeReduce <= charging && regulating;
         chargePhaseCode <= next_phase;
         currentSelect <= !batAbove2v ? 2'h0 : (!batAbove3v ? 2'h1 : 2'h2);
         indicatorOut <= 1'b0;
         // Open drain: a high level is released, never driven
         indicatorOe_n <= indicatorDisableBit || next_indicator;
         safetyFault <= timerExpired || (safetyFault && !toggled); // Sticky until host toggle
      end
   end

   safety_timer #(
      .WIDTH(TIMER_WIDTH)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .run(charging),
      .halfRate(regAny),
      .tick(timerTick),
      .limit(timerLimit),
      .expired(timerExpired)
   );

   alert_pulser #(
      .WIDTH(`ALERT_WIDTH)
   ) u_alert (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .req(alertReq),
      .pulse(hostAlert)
   );

   property p_floor_ro;
      @(posedge clk) disable iff (rst)
      (ce && !absoluteFloorSelect && !floorAlgoDone) |=> $stable(inputVoltageFloor);
   endproperty
   a_floor_ro: assert property (p_floor_ro) else $error("Floor changed without algorithm");
   property p_floor_wr;
      @(posedge clk) disable iff (rst)
      (ce && absoluteFloorSelect && floorWrite) |=> (inputVoltageFloor == $past(floorWriteData));
   endproperty
   a_floor_wr: assert property (p_floor_wr) else $error("Host floor write lost");
   property p_soft;
      @(posedge clk) disable iff (rst)
      (ce && !sysAbove2v2) |=> (appliedInputCap <= `SOFTSTART_CAP);
   endproperty
   a_soft: assert property (p_soft) else $error("Soft-start cap exceeded");
   property p_rate;
      @(posedge clk) disable iff (rst)
      (ce && boostEnableBit) |=> $stable(boostRateSelect);
   endproperty
   a_rate: assert property (p_rate) else $error("Boost rate changed while enabled");
   property p_boost_kind;
      @(posedge clk) disable iff (rst)
      (ce && boostActive) |-> (inputSourceKind == `SRC_KIND_BOOST);
   endproperty
   a_boost_kind: assert property (p_boost_kind) else $error("Boost kind not 111");
   property p_boost_cond;
      @(posedge clk) disable iff (rst)
      (ce && !boostOk) |=> !boostActive;
   endproperty
   a_boost_cond: assert property (p_boost_cond) else $error("Boost without conditions");
   property p_start;
      @(posedge clk) disable iff (rst)
      (ce && state == charger_pkg::CHG_IDLE && !canStart) |=> (state == charger_pkg::CHG_IDLE);
   endproperty
   a_start: assert property (p_start) else $error("Cycle started illegally");
   property p_term;
      @(posedge clk) disable iff (rst)
      (ce && state == charger_pkg::CHG_FAST && regAny) |=> (state != charger_pkg::CHG_DONE);
   endproperty
   a_term: assert property (p_term) else $error("Terminated during regulation");
   property p_done_alert;
      @(posedge clk) disable iff (rst)
      (ce && state == charger_pkg::CHG_FAST && next_state == charger_pkg::CHG_DONE)
         |-> ##[1:12] hostAlert;
   endproperty
   a_done_alert: assert property (p_done_alert) else $error("No alert at completion");
   c_done: cover property (@(posedge clk) state == charger_pkg::CHG_DONE);
   c_boost: cover property (@(posedge clk) boostActive);
   c_floor: cover property (@(posedge clk) floorAlgoDone ##[1:8] hostAlert);
endmodule
`default_nettype wire

//--- rtl/charger_defines.svh
// Constants for the charger control sequencer: codes, defaults and timing counts.
// Assumes a 40 MHz core clock; register fields are raw codes set by the host.
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH
`define CLK_PERIOD_NS 25
`define BOOST_DELAY_MS 30
`define BOOST_DELAY_CYCLES ((`BOOST_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define ALERT_WIDTH 4
`define SRC_KIND_BOOST 3'h7
`define PHASE_OFF 2'h0
`define PHASE_PRE 2'h1
`define PHASE_FAST 2'h2
`define PHASE_DONE 2'h3
`define FAST_CUR_RST 7'h20
`define PRE_CUR_RST 4'h1
`define TERM_CUR_RST 4'h3
`define CHG_VOLT_RST 6'h17
`define SAFETY_HOURS_RST 2'h2
`define BOOST_VOLT_RST 4'h7
`define MIN_SYS_RST 3'h5
`define SOFTSTART_CAP 6'h02
`define BLINK_BIT 22
`endif

//--- rtl/charger_pkg.sv
// Types shared by the charger sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package charger_pkg;
   typedef enum logic [3:0] {
      CHG_IDLE = 4'h1,
      CHG_PRE = 4'h2,
      CHG_FAST = 4'h4,
      CHG_DONE = 4'h8
   } chg_state_t;
endpackage

//--- rtl/safety_timer.sv
// Charge safety timer counting base ticks, at half rate during regulation.
// Assumes tick is a one-cycle strobe from a slow time base.
`timescale 1ns/1ps
`default_nettype none
module safety_timer #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic run,
   input wire logic halfRate,
   input wire logic tick,
   input wire logic [WIDTH-1:0] limit,
   output logic expired
);
   logic [WIDTH-1:0] count;
   logic skip;
   wire countNow = run && tick && (!halfRate || skip);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         skip <= 1'b0;
         expired <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            count <= '0;
            skip <= 1'b0;
         end else begin
            if (tick) begin
               skip <= !skip;
            end
            if (countNow && !expired) begin
               count <= count + 1'b1;
            end
         end
         expired <= run && (count >= limit) && (limit != '0);
      end
   end
   property p_half;
      @(posedge clk) disable iff (rst)
      (ce && run && tick && halfRate && !skip) |=> ($stable(count));
   endproperty
   a_half: assert property (p_half) else $error("Timer advanced on skipped tick");
endmodule
`default_nettype wire

//--- sim/charger_control_sequencer_tb.sv
// Self-checking bench for the charger sequencer with a host alert model.
// Assumes the design files and charger_defines.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"
module charger_control_sequencer_tb;
   typedef struct {int sel; logic [31:0] val;} note_t;
   note_t notes[$];
   note_t cur;
   logic [31:0] got;
   logic [31:0] seed = 32'hae01;
   int errCount = 0, nTests = 0, cycles = 0, alertCount, lastAlerts;
   logic widthBad;
   logic clk = '0, rst = '1, ce = '1, absoluteFloorSelect = '0, floorWrite = '0;
   logic [7:0] floorWriteData = '0, floorAlgoValue = '0;
   logic [5:0] inputCurrentCapSetting = '0, currentCapPin = '0, searchResult = '0;
   logic currentCapPinEnable = '0, inputCurrentSearchEnable = '0, runCurrentSearchNow = '0;
   logic searchDone = '0, chargingPortDetected = '0, sysAbove2v2 = '0, batAboveLow = '0;
   logic inputBelowSleep = '0, hostSupplyPin = '0, boostEnableBit = '0, thermBoostOk = '0;
   logic rateWrite = '0, rateWriteData = '0, sysAtMinimum = '0, inputOverCurrent = '0;
   logic [3:0] boostOutputVoltageSelect = '0;
   logic [2:0] sourceKindDetected = '0;
   logic inputUnderFloor = '0, thermalRegulating = '0, converterRunning = '0, chargeEnableBit = '0;
   logic chargeAllowPin_n = '0, thermFault = '0, batterySwitchOffBit = '0, currentBelowTerm = '0;
   logic batAboveRecharge = '0, batAbove2v = '0, batAbove3v = '0, indicatorDisableBit = '0;
   logic timerTick = '0, floorAlgoDone = '0;
   logic [6:0] fastChargeCurrentSetting = '0;
   logic [15:0] timerLimit = '0;
   logic [7:0] inputVoltageFloor;
   logic [5:0] activeInputCurrentCap, appliedInputCap, chargeVoltageCode;
   logic searchRunning, boostActive, boostRateSelect, minSystemRegulatingFlag, chargeReduce;
   logic voltageFloorActiveFlag, currentCapActiveFlag, indicatorOut, indicatorOe_n, hostAlert;
   logic safetyFault;
   logic [3:0] boostVoltage, precharge, termination;
   logic [2:0] inputSourceKind;
   logic [1:0] chargePhaseCode, currentSelect, safetyHours;

   charger_control_sequencer #(.BOOST_DELAY(20), .TIMER_WIDTH(16)) charger_control_sequencer_i (
      .clk, .rst, .ce, .absoluteFloorSelect, .floorWrite, .floorWriteData, .floorAlgoValue,
      .floorAlgoDone, .inputCurrentCapSetting, .currentCapPin, .currentCapPinEnable,
      .inputCurrentSearchEnable, .runCurrentSearchNow, .searchDone, .searchResult,
      .chargingPortDetected, .sysAbove2v2, .batAboveLow, .inputBelowSleep, .hostSupplyPin,
      .boostEnableBit, .thermBoostOk, .rateWrite, .rateWriteData, .boostOutputVoltageSelect,
      .sourceKindDetected, .sysAtMinimum, .inputOverCurrent, .inputUnderFloor, .thermalRegulating,
      .converterRunning, .chargeEnableBit, .chargeAllowPin_n, .fastChargeCurrentSetting,
      .thermFault, .batterySwitchOffBit, .currentBelowTerm, .batAboveRecharge, .batAbove2v,
      .batAbove3v, .indicatorDisableBit, .timerTick, .timerLimit, .inputVoltageFloor,
      .activeInputCurrentCap, .appliedInputCap, .searchRunning, .boostActive, .boostRateSelect,
      .boostVoltage, .inputSourceKind, .minSystemRegulatingFlag, .voltageFloorActiveFlag,
      .currentCapActiveFlag, .chargeReduce, .chargePhaseCode, .currentSelect, .indicatorOut,
      .indicatorOe_n, .hostAlert, .safetyFault, .chargeVoltageCode, .precharge, .termination,
      .safetyHours);
   host_model host_model_i (.clk, .rst, .hostAlert, .alertCount, .widthBad);

   always #12.5 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [5:0] mn(input logic [5:0] a, input logic [5:0] b);
      return (a < b) ? a : b;
   endfunction
   function automatic logic [31:0] obs(input int s);
      case (s)
         0: return {24'h0, inputVoltageFloor};
         1: return {26'h0, activeInputCurrentCap};
         2: return {26'h0, appliedInputCap};
         3: return {31'h0, boostActive};
         4: return {31'h0, boostRateSelect};
         5: return {29'h0, inputSourceKind};
         6: return {28'h0, minSystemRegulatingFlag, voltageFloorActiveFlag, currentCapActiveFlag,
            chargeReduce};
         7: return {30'h0, chargePhaseCode};
         8: return {30'h0, indicatorOut, indicatorOe_n};
         9: return {31'h0, safetyFault};
         10: return alertCount;
         11: return {31'h0, searchRunning};
         12: return {28'h0, boostVoltage};
         13: return {30'h0, currentSelect};
         14: return {16'h0, chargeVoltageCode, precharge, termination, safetyHours};
         default: return {31'h0, widthBad};
      endcase
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic want(input int s, input logic [31:0] v);
      notes.push_back('{s, v});
   endtask
   // A one-cycle strobe, then two edges so registered outputs have settled
   task automatic strobe(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(2);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         strobe(timerTick);
      end
   endtask
   task automatic completeRun();
      if (errCount == 0 && nTests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Results are compared as they are noted; outputs are settled at the falling edge
   initial forever begin
      wait (notes.size() != 0);
      cur = notes.pop_front();
      got = obs(cur.sel);
      nTests++;
      if (got !== cur.val) begin
         errCount++;
         $display("[ERR] %0t sel %0d got %h exp %h", $time, cur.sel, got, cur.val);
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         errCount++;
         completeRun();
      end
   end

   initial begin
      logic [31:0] r;
      cyc(20);
      rst = '0;
      cyc(2);
      want(14, {16'h0, `CHG_VOLT_RST, `PRE_CUR_RST, `TERM_CUR_RST, `SAFETY_HOURS_RST});
      want(7, 0);
      want(8, 1);
      r = rnd();
      floorWriteData = r[7:0];
      floorAlgoValue = r[15:8];
      strobe(floorWrite);
      want(0, 0);
      strobe(floorAlgoDone);
      want(0, r[15:8]);
      cyc(6);
      want(10, 1);
      absoluteFloorSelect = '1;
      floorWriteData = r[23:16];
      strobe(floorWrite);
      floorAlgoValue = r[31:24];
      strobe(floorAlgoDone);
      want(0, r[23:16]);
      cyc(6);
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         inputCurrentSearchEnable = '0;
         sysAbove2v2 = '0;
         currentCapPinEnable = '1;
         inputCurrentCapSetting = r[5:0];
         currentCapPin = r[11:6];
         searchResult = r[17:12];
         cyc(3);
         want(2, mn(r[5:0], `SOFTSTART_CAP));
         sysAbove2v2 = '1;
         cyc(3);
         want(2, mn(r[5:0], r[11:6]));
         strobe(chargingPortDetected);
         want(11, 0);
         inputCurrentSearchEnable = '1;
         strobe(chargingPortDetected);
         want(11, 1);
         currentCapPinEnable = '0;
         strobe(searchDone);
         want(11, 0);
         want(1, r[17:12]);
         strobe(runCurrentSearchNow);
         want(11, 1);
         currentCapPinEnable = '1;
         strobe(searchDone);
         want(1, mn(r[17:12], r[11:6]));
         want(2, mn(r[17:12], r[11:6]));
      end
      sourceKindDetected = 3'h2;
      boostOutputVoltageSelect = 4'h3;
      rateWriteData = '1;
      strobe(rateWrite);
      want(4, 1);
      want(12, 4'h3);
      for (int k = 0; k < 5; k++) begin
         {batAboveLow, inputBelowSleep, hostSupplyPin, boostEnableBit, thermBoostOk} =
            5'h1f ^ (5'h1 << k);
         cyc(30);
         want(3, 0);
      end
      {batAboveLow, inputBelowSleep, hostSupplyPin, boostEnableBit, thermBoostOk} = 5'h1f;
      rateWriteData = '0;
      strobe(rateWrite);
      cyc(9);
      want(3, 0);
      want(4, 1);
      cyc(15);
      want(3, 1);
      want(5, 7);
      hostSupplyPin = '0;
      cyc(4);
      want(3, 0);
      want(5, 2);
      converterRunning = '1;
      chargeEnableBit = '1;
      fastChargeCurrentSetting = `FAST_CUR_RST;
      batAbove2v = '1;
      cyc(4);
      want(7, `PHASE_PRE);
      want(13, 1);
      want(8, 0);
      indicatorDisableBit = '1;
      cyc(3);
      want(8, 1);
      indicatorDisableBit = '0;
      batAbove3v = '1;
      cyc(4);
      want(7, `PHASE_FAST);
      want(13, 2);
      for (int i = 0; i < 8; i++) begin
         {sysAtMinimum, inputUnderFloor, inputOverCurrent} = i[2:0];
         cyc(3);
         want(6, {i[2], i[1], i[0], i[1] | i[0]});
      end
      {sysAtMinimum, inputUnderFloor, inputOverCurrent} = 3'h0;
      thermalRegulating = '1;
      currentBelowTerm = '1;
      batAboveRecharge = '1;
      cyc(5);
      want(7, `PHASE_FAST);
      lastAlerts = alertCount;
      thermalRegulating = '0;
      cyc(10);
      want(7, `PHASE_DONE);
      want(8, 1);
      want(10, lastAlerts + 1);
      currentBelowTerm = '0;
      batAboveRecharge = '0;
      cyc(6);
      want(7, `PHASE_FAST);
      chargeEnableBit = '0;
      cyc(4);
      want(7, `PHASE_OFF);
      chargeEnableBit = '1;
      cyc(4);
      want(7, `PHASE_FAST);
      for (int k = 0; k < 5; k++) begin
         chargeEnableBit = '0;
         cyc(3);
         if (k == 4) fastChargeCurrentSetting = '0;
         else {converterRunning, chargeAllowPin_n, thermFault, batterySwitchOffBit} =
            4'h8 ^ (4'h1 << k);
         chargeEnableBit = '1;
         cyc(4);
         want(7, `PHASE_OFF);
         {converterRunning, chargeAllowPin_n, thermFault, batterySwitchOffBit} = 4'h8;
         fastChargeCurrentSetting = `FAST_CUR_RST;
      end
      cyc(4);
      timerLimit = 16'h4;
      thermalRegulating = '1;
      ticks(6);
      want(9, 0);
      ticks(4);
      want(9, 1);
      rst = '1;
      cyc(2);
      rst = '0;
      cyc(1);
      want(9, 0);
      want(14, {16'h0, `CHG_VOLT_RST, `PRE_CUR_RST, `TERM_CUR_RST, `SAFETY_HOURS_RST});
      thermalRegulating = '0;
      cyc(4);
      ticks(3);
      want(9, 0);
      ticks(3);
      want(9, 1);
      want(15, 0);
      ce = '0;
      strobe(floorAlgoDone);
      ce = '1;
      cyc(6);
      want(10, 0);
      cyc(2);
      completeRun();
   end
endmodule
`default_nettype wire

//--- sim/host_model.sv
// Host side model: watches the alert line, counts pulses and checks their width.
// Assumes the alert is an active-high pulse on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"
module host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic hostAlert,
   output int alertCount,
   output logic widthBad
);
   int width;
   // Pulses are counted at their falling edge, so merged events show as a short count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         width <= 0;
         alertCount <= 0;
         widthBad <= 1'b0;
      end else if (hostAlert) begin
         width <= width + 1;
      end else begin
         if (width != 0) begin
            alertCount <= alertCount + 1;
            if (width != `ALERT_WIDTH) widthBad <= 1'b1;
         end
         width <= 0;
      end
   end
endmodule
`default_nettype wire
